// *** rtl/tsw_defines.svh ***
// Constants for the tire sensor mode and wake logic.
`ifndef TSW_DEFINES_SVH
`define TSW_DEFINES_SVH

// Reference clock period in nanoseconds (250 MHz).
`define TSW_REF_PERIOD_NS 4
// Low-frequency oscillator: 5.4 kHz, period in nanoseconds.
`define TSW_OSC_FREQ_HZ 5400
`define TSW_OSC_PERIOD_NS (1000000000 / `TSW_OSC_FREQ_HZ)
// Reference cycles per oscillator period.
`define TSW_OSC_DIV_CYCLES (`TSW_OSC_PERIOD_NS / `TSW_REF_PERIOD_NS)
// Wake divider stages (divide by 16384).
`define TSW_WAKE_STAGES 14
// Further host-reset divider stages.
`define TSW_RST_STAGES 10
// Host-reset pulse length in oscillator cycles.
`define TSW_RST_PULSE_OSC 2'h2
// Bits per serial threshold word.
`define TSW_THR_BITS 8
// Falling-edge index that loads the threshold (eighth edge).
`define TSW_LOAD_EDGE 3'h7
// Mode pin codes {high, low}.
`define TSW_CODE_STBY 2'h0
`define TSW_CODE_PRES 2'h1
`define TSW_CODE_TEMP 2'h2
`define TSW_CODE_READ 2'h3

`endif

// *** rtl/tsw_pkg.sv ***
// Types shared by the tire sensor mode and wake logic.
package tsw_pkg;

  // Operating mode, one-hot.
  typedef enum logic [3:0] {
    TSW_STBY = 4'h1,
    TSW_PRES = 4'h2,
    TSW_TEMP = 4'h4,
    TSW_READ = 4'h8
  } tsw_mode_t;

  // Controls for the analog measuring front end.
  typedef struct packed {
    logic pres_pwr;
    logic pres_mux;
    logic temp_pwr;
    logic temp_mux;
    logic cmp_en;
  } tsw_ana_ctrl_t;

endpackage : tsw_pkg

// *** rtl/tsw_top.sv ***
// Mode decode, analog sequencing, wake dividers and serial threshold load.
//
// Operation
// [R1] Divide the 5.4 kHz oscillator by 16384; each overflow gives a wake pulse.
// [R2] A further 10-stage divider overflows to give a host-reset pulse.
// [R3] Mode pins decode four modes; comparator enabled only in output read.
// [R4] Multiplexers, threshold, oscillator and dividers stay active in every mode; here each multiplexer closes only in its own measure mode.
// [R5] Low pin alone powers pressure circuit and routes it to the sample.
// [R6] Low pin falling: open pressure path first, then remove its power.
// [R7] High pin alone powers temperature circuit and routes it to the sample.
// [R8] High pin falling: open temperature path first, then remove its power.
// [R9] Outside standby the output pin carries the comparator result.
// [R10] In standby the output is high, pulsed low on each wake overflow.
// [R11] Host may check one alarm threshold or run an 8-bit approximation.
// [R12] Serial bit counter clears in measure modes, counts otherwise.
// [R13] Bits shift in MSB first on rising edges; load on eighth falling.
// [R14] Host-reset pin pulses low two oscillator cycles; output pulses too.
// [R15] Host leaves serial pins still in measure modes.
// [R16] Standby wake pulse lasts exactly one oscillator cycle.
`timescale 1ns/1ps
`default_nettype none
`include "tsw_defines.svh"

module tsw_top
  import tsw_pkg::*;
#(
  parameter int OSC_DIV_CYCLES = `TSW_OSC_DIV_CYCLES,
  parameter int WAKE_STAGES = `TSW_WAKE_STAGES,
  parameter int RST_STAGES = `TSW_RST_STAGES
) (
  // Reference clock and reset.
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  // Mode pins from the host.
  input wire logic I_MODE_SELECT_LOW,
  input wire logic I_MODE_SELECT_HIGH,
  // Serial threshold link from the host.
  input wire logic I_SER_CLK,
  input wire logic I_SER_DATA,
  // Comparator result from the analog section.
  input wire logic I_CMP_ABOVE,
  // Output pin, host-reset pin and analog controls.
  output logic O_OUT,
  output logic O_RST_N,
  output var tsw_ana_ctrl_t O_ANA_CTRL,
  output logic [`TSW_THR_BITS-1:0] O_DAC_CODE
);

  localparam int TOTAL_STAGES = WAKE_STAGES + RST_STAGES;
  localparam int OCW = $clog2(OSC_DIV_CYCLES + 1);
  localparam logic [OCW-1:0] OSC_LAST = OCW'(OSC_DIV_CYCLES - 1);

  logic rst_meta_ff;
  logic rstn_ff;
  logic [1:0] pin_meta_ff;
  logic [1:0] pin_sync_ff;
  logic cmp_meta_ff;
  logic cmp_sync_ff;
  tsw_mode_t mode_ff;
  tsw_mode_t nxt_mode;
  tsw_ana_ctrl_t ctrl_ff;
  logic [OCW-1:0] osc_cnt_ff;
  logic osc_tick_ff;
  logic [TOTAL_STAGES-1:0] div_ff;
  logic wake_ovf;
  logic rst_ovf;
  logic wake_ff;
  logic [1:0] rst_left_ff;
  logic out_ff;
  logic rst_n_ff;
  logic link_rst_n_ff;
  logic [`TSW_THR_BITS-1:0] shift_ff;
  logic [2:0] fall_cnt_ff;
  logic [`TSW_THR_BITS-1:0] byte_ff;
  logic load_tgl_ff;
  logic tgl_meta_ff;
  logic tgl_sync_ff;
  logic tgl_seen_ff;
  logic [`TSW_THR_BITS-1:0] thr_ff;

  // Reset release through two flip-flops.
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rst_meta_ff <= 1'b0;
      rstn_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rstn_ff <= rst_meta_ff;
    end
  end

  // Two-stage synchronisers for the mode pins and the comparator.
  always_ff @(posedge I_REF_CLK or negedge rstn_ff) begin
    if (!rstn_ff) begin
      pin_meta_ff <= 2'h0;
      pin_sync_ff <= 2'h0;
      cmp_meta_ff <= 1'b0;
      cmp_sync_ff <= 1'b0;
    end else begin
      pin_meta_ff <= {I_MODE_SELECT_HIGH, I_MODE_SELECT_LOW};
      pin_sync_ff <= pin_meta_ff;
      cmp_meta_ff <= I_CMP_ABOVE;
      cmp_sync_ff <= cmp_meta_ff;
    end
  end

  // Decode of the two mode pins.
  always_comb begin
    case (pin_sync_ff) // R3
      `TSW_CODE_STBY: nxt_mode = TSW_STBY;
      `TSW_CODE_PRES: nxt_mode = TSW_PRES;
      `TSW_CODE_TEMP: nxt_mode = TSW_TEMP;
      `TSW_CODE_READ: nxt_mode = TSW_READ;
      default: nxt_mode = TSW_STBY;
    endcase
  end

  // Mode register.
  always_ff @(posedge I_REF_CLK or negedge rstn_ff) begin
    if (!rstn_ff) begin
      mode_ff <= TSW_STBY;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // Analog sequencing: a path closes with its power and opens a cycle
  // before its power drops, so the sample is held before the circuit dies.
  always_ff @(posedge I_REF_CLK or negedge rstn_ff) begin
    if (!rstn_ff) begin
      ctrl_ff <= '0;
    end else begin
      ctrl_ff.pres_mux <= (mode_ff == TSW_PRES); // R5
      ctrl_ff.pres_pwr <= (mode_ff == TSW_PRES) || ctrl_ff.pres_mux; // R6
      ctrl_ff.temp_mux <= (mode_ff == TSW_TEMP); // R7
      ctrl_ff.temp_pwr <= (mode_ff == TSW_TEMP) || ctrl_ff.temp_mux; // R8
      ctrl_ff.cmp_en <= (mode_ff == TSW_READ); // R3
    end
  end

  // Oscillator tick from the reference clock; runs in every mode.
  always_ff @(posedge I_REF_CLK or negedge rstn_ff) begin
    if (!rstn_ff) begin
      osc_cnt_ff <= '0;
      osc_tick_ff <= 1'b0;
    end else begin
      osc_tick_ff <= (osc_cnt_ff == OSC_LAST); // R4
      osc_cnt_ff <= (osc_cnt_ff == OSC_LAST) ? '0 : osc_cnt_ff + 1'b1;
    end
  end

  // Divider chain counting oscillator cycles.
  always_ff @(posedge I_REF_CLK or negedge rstn_ff) begin
    if (!rstn_ff) begin
      div_ff <= '0;
    end else if (osc_tick_ff) begin
      div_ff <= div_ff + 1'b1; // R4
    end
  end

  assign wake_ovf = osc_tick_ff && (&div_ff[WAKE_STAGES-1:0]); // R1
  assign rst_ovf = osc_tick_ff && (&div_ff); // R2

  // Wake pulse held for one oscillator cycle.
  always_ff @(posedge I_REF_CLK or negedge rstn_ff) begin
    if (!rstn_ff) begin
      wake_ff <= 1'b0;
    end else if (osc_tick_ff) begin
      wake_ff <= wake_ovf; // R16
    end
  end

  // Host-reset pulse held for two oscillator cycles.
  always_ff @(posedge I_REF_CLK or negedge rstn_ff) begin
    if (!rstn_ff) begin
      rst_left_ff <= 2'h0;
    end else if (rst_ovf) begin
      rst_left_ff <= `TSW_RST_PULSE_OSC; // R14
    end else if (osc_tick_ff && rst_left_ff != 2'h0) begin
      rst_left_ff <= rst_left_ff - 2'h1;
    end
  end

  // Output pin: reset pulse in any mode, wake pulse in standby,
  // comparator result otherwise.
  always_ff @(posedge I_REF_CLK or negedge rstn_ff) begin
    if (!rstn_ff) begin
      out_ff <= 1'b1;
      rst_n_ff <= 1'b1;
    end else begin
      rst_n_ff <= (rst_left_ff == 2'h0); // R14
      if (rst_left_ff != 2'h0) begin
        out_ff <= 1'b0; // R14
      end else if (mode_ff == TSW_STBY) begin
        out_ff <= ~wake_ff; // R10
      end else begin
        out_ff <= cmp_sync_ff; // R9
      end
    end
  end

  // Link-side reset: held while a measure mode is active.
  always_ff @(posedge I_REF_CLK or negedge rstn_ff) begin
    if (!rstn_ff) begin
      link_rst_n_ff <= 1'b0;
    end else begin
      link_rst_n_ff <= (mode_ff != TSW_PRES) && (mode_ff != TSW_TEMP); // R12
    end
  end

  // Shift register on rising serial clock, MSB first.
  always_ff @(posedge I_SER_CLK or negedge link_rst_n_ff) begin
    if (!link_rst_n_ff) begin
      shift_ff <= '0;
    end else begin
      shift_ff <= {shift_ff[`TSW_THR_BITS-2:0], I_SER_DATA}; // R13
    end
  end

  // Bit counter on falling serial clock, cleared in measure modes.
  always_ff @(negedge I_SER_CLK or negedge link_rst_n_ff) begin
    if (!link_rst_n_ff) begin
      fall_cnt_ff <= 3'h0; // R12
    end else begin
      fall_cnt_ff <= fall_cnt_ff + 3'h1; // R12
    end
  end

  // Eighth edge captures the word; measure modes leave it and its toggle.
  always_ff @(negedge I_SER_CLK or negedge rstn_ff) begin
    if (!rstn_ff) begin
      byte_ff <= '0;
      load_tgl_ff <= 1'b0;
    end else if (fall_cnt_ff == `TSW_LOAD_EDGE) begin
      byte_ff <= shift_ff; // R13
      load_tgl_ff <= ~load_tgl_ff;
    end
  end

  // Load event crosses by toggle; the word is stable long before it lands.
  always_ff @(posedge I_REF_CLK or negedge rstn_ff) begin
    if (!rstn_ff) begin
      tgl_meta_ff <= 1'b0;
      tgl_sync_ff <= 1'b0;
      tgl_seen_ff <= 1'b0;
    end else begin
      tgl_meta_ff <= load_tgl_ff;
      tgl_sync_ff <= tgl_meta_ff;
      tgl_seen_ff <= tgl_sync_ff;
    end
  end

  // Threshold register, kept through every mode.
  always_ff @(posedge I_REF_CLK or negedge rstn_ff) begin
    if (!rstn_ff) begin
      thr_ff <= '0;
    end else if (tgl_sync_ff != tgl_seen_ff) begin
      thr_ff <= byte_ff; // R13
    end
  end

  assign O_OUT = out_ff;
  assign O_RST_N = rst_n_ff;
  assign O_ANA_CTRL = ctrl_ff;
  assign O_DAC_CODE = thr_ff;

  // Helper: oscillator cycles seen while the host reset is low.
  logic [2:0] rst_ticks_ff;
  always_ff @(posedge I_REF_CLK or negedge rstn_ff) begin
    if (!rstn_ff) begin
      rst_ticks_ff <= 3'h0;
    end else if (rst_n_ff) begin
      rst_ticks_ff <= 3'h0;
    end else if (osc_tick_ff) begin
      rst_ticks_ff <= rst_ticks_ff + 3'h1;
    end
  end

  // Checks on the reference-clock side.
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!rstn_ff);

  // Each pressure path opening is followed by power removal.
  pres_hold_order_a: assert property ($fell(ctrl_ff.pres_mux) |-> // R6
    ctrl_ff.pres_pwr ##1 (!ctrl_ff.pres_pwr || ctrl_ff.pres_mux))
    else $error("Pressure power dropped out of order.");

  // Each temperature path opening is followed by power removal.
  temp_hold_order_a: assert property ($fell(ctrl_ff.temp_mux) |-> // R8
    ctrl_ff.temp_pwr ##1 (!ctrl_ff.temp_pwr || ctrl_ff.temp_mux))
    else $error("Temperature power dropped out of order.");

  // Pressure mode routes and powers the pressure circuit.
  pres_route_a: assert property ((mode_ff == TSW_PRES) |=> // R5
    ctrl_ff.pres_mux && ctrl_ff.pres_pwr && !ctrl_ff.temp_mux)
    else $error("Pressure path not routed.");

  // Temperature mode routes and powers the temperature circuit.
  temp_route_a: assert property ((mode_ff == TSW_TEMP) |=> // R7
    ctrl_ff.temp_mux && ctrl_ff.temp_pwr && !ctrl_ff.pres_mux)
    else $error("Temperature path not routed.");

  // Comparator enabled exactly in output read.
  cmp_enable_a: assert property (ctrl_ff.cmp_en == // R3
    $past(mode_ff == TSW_READ))
    else $error("Comparator enable does not follow mode.");

  // Standby output low only for wake or reset pulses.
  standby_out_a: assert property (($past(mode_ff) == TSW_STBY &&
    !$past(wake_ff) && $past(rst_left_ff) == 2'h0) |-> out_ff) // R10
    else $error("Standby output low without a pulse.");

  // Wake pulse starts only on a 16384 overflow tick.
  wake_start_a: assert property ($rose(wake_ff) |-> // R1
    $past(osc_tick_ff) && $past(div_ff[WAKE_STAGES-1:0]) == '1)
    else $error("Wake pulse without divider overflow.");

  // Wake pulse ends on the next oscillator tick only.
  wake_width_a: assert property ($fell(wake_ff) |-> // R16
    $past(osc_tick_ff))
    else $error("Wake pulse not one oscillator cycle.");

  // Host reset low lasts two oscillator cycles, output low with it.
  rst_width_a: assert property ($rose(rst_n_ff) |-> // R14
    $past(rst_ticks_ff) == 3'h2)
    else $error("Host reset pulse has wrong length.");

  rst_with_out_a: assert property (!rst_n_ff |-> !out_ff) // R14
    else $error("Output not pulsed with host reset.");

  // Measure modes hold the serial counter cleared.
  cnt_clear_a: assert property (((mode_ff == TSW_PRES) || // R12
    (mode_ff == TSW_TEMP)) |=> !link_rst_n_ff ##1 fall_cnt_ff == 3'h0)
    else $error("Serial counter not cleared in measure mode.");

  // A landed load copies the captured word within one cycle.
  thr_load_a: assert property ((tgl_sync_ff != tgl_seen_ff) |=> // R13
    thr_ff == $past(byte_ff))
    else $error("Threshold register not loaded.");

  // Eighth falling edge captures the shifted word.
  link_capture_a: assert property (@(negedge I_SER_CLK)
    disable iff (!link_rst_n_ff)
    ($past(fall_cnt_ff) == 3'h7) |-> byte_ff == $past(shift_ff)) // R13
    else $error("Serial word not captured on eighth edge.");

  // Main scenarios.
  wake_seen_c: cover property ((mode_ff == TSW_STBY) && !out_ff);
  rst_seen_c: cover property ($fell(rst_n_ff));
  pres_cycle_c: cover property ($fell(ctrl_ff.pres_mux) ##1
    $fell(ctrl_ff.pres_pwr));
  thr_load_c: cover property ((mode_ff == TSW_READ) &&
    (tgl_sync_ff != tgl_seen_ff));

endmodule : tsw_top

`default_nettype wire

// *** tb/tsw_host_model.sv ***
// Host model driving the mode pins and the serial threshold link.
`timescale 1ns/1ps
`default_nettype none

module tsw_host_model (
  // Pins toward the sensor.
  output logic o_mode_lo,
  output logic o_mode_hi,
  output logic o_ser_clk,
  output logic o_ser_data
);
  // All pins start low, as their pull-downs would leave them.
  initial begin
    o_mode_lo = 1'b0;
    o_mode_hi = 1'b0;
    o_ser_clk = 1'b0;
    o_ser_data = 1'b0;
  end

  // Drives one of the four mode codes as {high, low}.
  task automatic set_mode(input logic [1:0] code);
    {o_mode_hi, o_mode_lo} = code;
  endtask : set_mode

  // Shifts n bits MSB first; the 64 ns clock runs only inside the frame.
  task automatic send_bits(input logic [7:0] val, input int n);
    #6;
    for (int i = 0; i < n; i++) begin
      o_ser_data = val[7-i];
      #16 o_ser_clk = 1'b1;
      #32 o_ser_clk = 1'b0;
      #16;
    end
    o_ser_data = 1'b0;
    // Returns one nanosecond after a reference edge, like the bench.
    #2;
  endtask : send_bits
endmodule : tsw_host_model
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the tire sensor mode and wake logic.
`timescale 1ns/1ps
`default_nettype none

module testbench
  import tsw_pkg::*;
;
  localparam int OSC = 4;
  logic clk;
  logic rst_n;
  logic cmp_above;
  logic mode_lo;
  logic mode_hi;
  logic ser_clk;
  logic ser_data;
  logic o_out;
  logic o_rst_n;
  tsw_ana_ctrl_t ana;
  logic [7:0] dac;
  int error_cnt = 0;
  int compares = 0;

  // Host on the far side of the mode pins and serial link.
  tsw_host_model host (.o_mode_lo(mode_lo), .o_mode_hi(mode_hi),
    .o_ser_clk(ser_clk), .o_ser_data(ser_data));

  // Short dividers: wake every 8 ticks, host reset every 32 ticks.
  tsw_top #(.OSC_DIV_CYCLES(OSC), .WAKE_STAGES(3), .RST_STAGES(2)) uut (
    .I_REF_CLK(clk), .I_RSTN(rst_n), .I_MODE_SELECT_LOW(mode_lo),
    .I_MODE_SELECT_HIGH(mode_hi), .I_SER_CLK(ser_clk),
    .I_SER_DATA(ser_data), .I_CMP_ABOVE(cmp_above), .O_OUT(o_out),
    .O_RST_N(o_rst_n), .O_ANA_CTRL(ana), .O_DAC_CODE(dac));

  // Reference clock, 4 ns period.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("Compares %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  // Compares a seen value against the expected one.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Waits n cycles and lands just after the edge.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // Counts cycles until the output or reset pin reaches a level.
  task automatic wait_sig(input bit sel, input logic lvl, output int n);
    n = 0;
    while ((sel ? o_rst_n : o_out) !== lvl && n < 400) begin
      cyc(1);
      n++;
    end
    if (n >= 400) begin
      error_cnt++;
      stop_test();
    end
  endtask : wait_sig

  // Enters a mode; checks controls and that a mux opens before power drops.
  task automatic mode_step(input logic [1:0] code, input logic [4:0] exp,
                           input logic hold);
    logic seen;
    seen = 1'b0;
    host.set_mode(code);
    for (int i = 0; i < 8; i++) begin
      cyc(1);
      if ((ana.pres_pwr && !ana.pres_mux) || (ana.temp_pwr && !ana.temp_mux))
        seen = 1'b1;
    end
    chk({3'h0, ana}, {3'h0, exp});
    chk({7'h0, seen}, {7'h0, hold});
  endtask : mode_step

  // Loads one threshold word and checks the register.
  task automatic load_check(input logic [7:0] val);
    host.send_bits(val, 8);
    cyc(6);
    chk(dac, val);
  endtask : load_check

  // Sets the comparator and checks the output pin outside standby.
  task automatic out_follow(input logic v);
    int n;
    cmp_above = v;
    cyc(5);
    // A host reset pulse overrides the pin, so look once it is over.
    wait_sig(1'b1, 1'b1, n);
    chk({7'h0, o_out}, {7'h0, v});
  endtask : out_follow

  // Measures the standby wake pulse width and spacing.
  task automatic wake_check();
    int n;
    wait_sig(1'b0, 1'b1, n);
    wait_sig(1'b0, 1'b0, n);
    if (o_rst_n === 1'b0) begin
      wait_sig(1'b0, 1'b1, n);
      wait_sig(1'b0, 1'b0, n);
    end
    wait_sig(1'b0, 1'b1, n);
    chk(n[7:0], OSC);
    wait_sig(1'b0, 1'b0, n);
    chk(n[7:0] + 8'h04, 8 * OSC);
  endtask : wake_check

  // Measures the host reset pulse, its echo on the output and its spacing.
  task automatic rst_check();
    int n;
    wait_sig(1'b1, 1'b1, n);
    wait_sig(1'b1, 1'b0, n);
    cyc(2);
    chk({7'h0, o_out}, 8'h00);
    wait_sig(1'b1, 1'b1, n);
    chk(n[7:0] + 8'h02, 2 * OSC);
    wait_sig(1'b1, 1'b0, n);
    chk(n[7:0] + 8'h08, 32 * OSC);
  endtask : rst_check

  // Main sequence.
  initial begin
    rst_n = 1'b0;
    cmp_above = 1'b0;
    cyc(8);
    chk({6'h0, o_out, o_rst_n}, 8'h03);
    chk({3'h0, ana}, 8'h00);
    rst_n = 1'b1;
    cyc(12);
    // Host stays in standby or read while it shifts.
    load_check(8'hA5);
    mode_step(2'h1, 5'h18, 1'b0);
    chk(dac, 8'hA5);
    mode_step(2'h0, 5'h00, 1'b1);
    mode_step(2'h2, 5'h06, 1'b0);
    mode_step(2'h0, 5'h00, 1'b1);
    host.send_bits(8'hF0, 4);
    mode_step(2'h3, 5'h01, 1'b0);
    out_follow(1'b1);
    out_follow(1'b0);
    mode_step(2'h1, 5'h18, 1'b0);
    out_follow(1'b1);
    mode_step(2'h2, 5'h06, 1'b1);
    out_follow(1'b0);
    mode_step(2'h3, 5'h01, 1'b1);
    load_check(8'h3C);
    host.send_bits(8'hFF, 8);
    load_check(8'h81);
    cmp_above = 1'b1;
    rst_check();
    mode_step(2'h0, 5'h00, 1'b0);
    wake_check();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
